// ### scss_defines.svh
// constants of the system clock source selector
// assumes inclusion by the package, the design and the bench
`ifndef SCSS_DEFINES_SVH
`define SCSS_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define SCSS_ADDR_CTRL 8'h00
`define SCSS_ADDR_STAT 8'h01
`define SCSS_ADDR_FREQ 8'h02

// ****************************************
// field positions
// ****************************************
`define SCSS_NEXT_DIVIDER_SELECT_MSB 3
`define SCSS_NEXT_DIVIDER_SELECT_LSB 0
`define SCSS_NEXT_SOURCE_SELECT_MSB 6
`define SCSS_NEXT_SOURCE_SELECT_LSB 4
`define SCSS_BUSY_BIT 7

// ****************************************
// source codes, reset values
// ****************************************
`define SCSS_NEXT_SOURCE_SELECT_EXT_PLL 3'h2
`define SCSS_NEXT_SOURCE_SELECT_HF      3'h6
`define SCSS_NEXT_SOURCE_SELECT_LF      3'h5
`define SCSS_NEXT_SOURCE_SELECT_EXT     3'h7
`define SCSS_NEXT_DIVIDER_SELECT_MAX     4'h9
`define SCSS_NEXT_DIVIDER_SELECT_RESET   4'h0
`define SCSS_FREQ_RESET   4'h2
`define SCSS_FREQ_MAX     4'h8

// ****************************************
// external oscillator modes
// ****************************************
`define SCSS_FEXT_ECH 3'h0
`define SCSS_FEXT_ECM 3'h1
`define SCSS_FEXT_ECL 3'h2
`define SCSS_FEXT_LP  3'h4
`define SCSS_FEXT_XT  3'h5
`define SCSS_FEXT_HS  3'h6

// ****************************************
// timing counts
// ****************************************
`define SCSS_OST_TICKS 10'h3ff

`endif

// ### scss_pkg.sv
// types of the system clock source selector
// assumes scss_defines.svh sits beside it
`include "scss_defines.svh"

package scss_pkg;
    typedef enum logic [1:0] {
        SRC_HF,
        SRC_LF,
        SRC_EXT,
        SRC_EXT_PLL
    } scss_src_t;

    typedef enum logic [1:0] {
        SW_IDLE,
        SW_WAIT_OLD,
        SW_START
    } scss_sw_state_t;
endpackage

// ### scss_top.sv
// system clock source selector: picks a source, divides it,
// switches glitch-free and drives the clock-out pin
// assumes fast, slow and PLL sources arrive as ticks synchronous to sys_clk; the first pin as a level whose rising edges count
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "scss_defines.svh"

// Behaviour
// - internal fast oscillator offers 1,2,4,8,12,16,32,48,64 MHz
// - software picks fast oscillator frequency via frequency register
// - slow internal oscillator is a fixed 31 kHz, not adjustable
// - system clock follows next-source field of control register
// - four-times PLL usable with the external clock
// - clock out drives second pin only if enabled and pin free
// - clock out runs at one quarter of system clock
// - after reset source comes from reset-source and external-mode config
// - writing next source and divider switches the clock at run time
// - external clock enters first pin, second pin freed
// - external clock has high, medium and low power levels
// - no start-up timer in external clock mode
// - stopped external clock halts block with state kept
// - low gain crystal mode sets lowest amplifier gain
// - medium gain crystal mode sets intermediate gain
// - high gain crystal mode sets highest gain
module scss_top
    import scss_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // configuration straps
    input  wire logic [2:0] reset_clock_source_cfg,
    input  wire logic [2:0] external_osc_mode_cfg,
    input  wire logic       clock_output_enable,
    // oscillator taps
    input  wire logic       crystal_in_pin,
    input  wire logic       hf_osc_tick,
    input  wire logic       lf_osc_tick,
    input  wire logic       pll_tick,
    // analog controls
    output logic      [3:0] internal_freq_select,
    output logic      [1:0] amp_gain,
    output logic      [1:0] ext_power,
    output logic            pll_enable,
    output logic            ost_active,
    // system clock
    output logic            fosc_tick,
    // second oscillator pin
    input  wire logic       clk_out_pin_in,
    output logic            clk_out_pin_out,
    output logic            clk_out_pin_oe,
    input  wire logic       gpio_out,
    input  wire logic       gpio_oe,
    output logic            gpio_in
);

    // ****************************************
    // code mapping
    // ****************************************
    function automatic scss_src_t code_to_src(input logic [2:0] c);
        scss_src_t s;
        s = SRC_HF;
        if (c == `SCSS_NEXT_SOURCE_SELECT_LF) s = SRC_LF;
        else if (c == `SCSS_NEXT_SOURCE_SELECT_EXT) s = SRC_EXT;
        else if (c == `SCSS_NEXT_SOURCE_SELECT_EXT_PLL) s = SRC_EXT_PLL;
        return s;
    endfunction

    function automatic logic code_ok(input logic [2:0] c);
        return c == `SCSS_NEXT_SOURCE_SELECT_HF || c == `SCSS_NEXT_SOURCE_SELECT_LF
            || c == `SCSS_NEXT_SOURCE_SELECT_EXT || c == `SCSS_NEXT_SOURCE_SELECT_EXT_PLL;
    endfunction

    function automatic logic [2:0] src_to_code(input scss_src_t s);
        logic [2:0] c;
        c = `SCSS_NEXT_SOURCE_SELECT_HF;
        case (s)
            SRC_LF:      c = `SCSS_NEXT_SOURCE_SELECT_LF;
            SRC_EXT:     c = `SCSS_NEXT_SOURCE_SELECT_EXT;
            SRC_EXT_PLL: c = `SCSS_NEXT_SOURCE_SELECT_EXT_PLL;
            default:     c = `SCSS_NEXT_SOURCE_SELECT_HF;
        endcase
        return c;
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [2:0]     next_source_select_reg;
    logic [3:0]     next_divider_select_reg;
    logic [3:0]     freq_reg;
    logic           cfg_loaded_reg;
    logic [2:0]     fext_reg;
    logic           cko_en_reg;
    scss_src_t      cur_src_reg;
    logic [3:0]     cur_div_reg;
    scss_sw_state_t state_reg;
    logic [8:0]     div_cnt_reg;
    logic [9:0]     ost_cnt_reg;
    logic [1:0]     cko_cnt_reg;
    logic           ext_prev_reg;
    logic           src_tick;
    logic           raw_tick;
    logic [8:0]     div_max;
    logic           xtal_mode;
    logic           ost_needed;
    logic           pending;
    logic           clkout_on;
    logic           ctrl_ok;

    // ****************************************
    // source taps
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= crystal_in_pin;
        end
    end

    // a stopped source gives no ticks, so the divider freezes and a switch waits in SW_WAIT_OLD
    always_comb begin
        case (cur_src_reg)
            SRC_LF:      src_tick = lf_osc_tick;
            SRC_EXT:     src_tick = crystal_in_pin & ~ext_prev_reg;
            SRC_EXT_PLL: src_tick = pll_tick;
            default:     src_tick = hf_osc_tick;
        endcase
    end

    assign xtal_mode = fext_reg == `SCSS_FEXT_LP || fext_reg == `SCSS_FEXT_XT
                    || fext_reg == `SCSS_FEXT_HS;
    assign ost_needed = xtal_mode
                     && (cur_src_reg == SRC_EXT || cur_src_reg == SRC_EXT_PLL);
    assign div_max = 9'((10'h1 << cur_div_reg) - 10'h1);
    assign raw_tick = src_tick && div_cnt_reg == div_max
                   && state_reg != SW_START;
    assign pending = code_to_src(next_source_select_reg) != cur_src_reg
                  || next_divider_select_reg != cur_div_reg;
    assign clkout_on = cko_en_reg && !xtal_mode && cfg_loaded_reg;
    assign ctrl_ok = code_ok(reg_wdata[`SCSS_NEXT_SOURCE_SELECT_MSB:`SCSS_NEXT_SOURCE_SELECT_LSB])
                  && reg_wdata[`SCSS_NEXT_DIVIDER_SELECT_MSB:`SCSS_NEXT_DIVIDER_SELECT_LSB] <= `SCSS_NEXT_DIVIDER_SELECT_MAX;

    // ****************************************
    // configuration capture
    // ****************************************
    // straps are caught on the first edge after release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_loaded_reg <= 1'b0;
            fext_reg       <= `SCSS_FEXT_ECH;
            cko_en_reg     <= 1'b0;
        end else if (!cfg_loaded_reg) begin
            cfg_loaded_reg <= 1'b1;
            fext_reg       <= external_osc_mode_cfg;
            cko_en_reg     <= clock_output_enable;
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    // a control write with a reserved code or divider is dropped
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            next_source_select_reg <= `SCSS_NEXT_SOURCE_SELECT_HF;
            next_divider_select_reg <= `SCSS_NEXT_DIVIDER_SELECT_RESET;
            freq_reg <= `SCSS_FREQ_RESET;
        end else if (!cfg_loaded_reg) begin
            next_source_select_reg <= src_to_code(code_to_src(reset_clock_source_cfg));
            next_divider_select_reg <= `SCSS_NEXT_DIVIDER_SELECT_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `SCSS_ADDR_CTRL && ctrl_ok) begin
                next_source_select_reg <= reg_wdata[`SCSS_NEXT_SOURCE_SELECT_MSB:`SCSS_NEXT_SOURCE_SELECT_LSB];
                next_divider_select_reg <= reg_wdata[`SCSS_NEXT_DIVIDER_SELECT_MSB:`SCSS_NEXT_DIVIDER_SELECT_LSB];
            end else if (reg_addr == `SCSS_ADDR_FREQ
                         && reg_wdata[3:0] <= `SCSS_FREQ_MAX) begin
                freq_reg <= reg_wdata[3:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `SCSS_ADDR_CTRL) begin
                reg_rdata <= {1'b0, next_source_select_reg, next_divider_select_reg};
            end else if (reg_addr == `SCSS_ADDR_STAT) begin
                reg_rdata <= {state_reg != SW_IDLE,
                              src_to_code(cur_src_reg), cur_div_reg};
            end else if (reg_addr == `SCSS_ADDR_FREQ) begin
                reg_rdata <= {4'h0, freq_reg};
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************
    // switch sequencer
    // ****************************************
    // the old source finishes its period before the new one is taken
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg   <= SW_START;
            cur_src_reg <= SRC_HF;
            cur_div_reg <= `SCSS_NEXT_DIVIDER_SELECT_RESET;
            ost_cnt_reg <= 10'h000;
        end else if (!cfg_loaded_reg) begin
            state_reg   <= SW_START;
            cur_src_reg <= code_to_src(reset_clock_source_cfg);
            cur_div_reg <= `SCSS_NEXT_DIVIDER_SELECT_RESET;
            ost_cnt_reg <= 10'h000;
        end else begin
            case (state_reg)
                SW_IDLE: begin
                    if (pending) state_reg <= SW_WAIT_OLD;
                end
                SW_WAIT_OLD: begin
                    if (raw_tick) begin
                        cur_src_reg <= code_to_src(next_source_select_reg);
                        cur_div_reg <= next_divider_select_reg;
                        ost_cnt_reg <= 10'h000;
                        state_reg   <= SW_START;
                    end
                end
                default: begin
                    if (!ost_needed) begin
                        state_reg <= SW_IDLE;
                    end else if (src_tick) begin
                        if (ost_cnt_reg == `SCSS_OST_TICKS) state_reg <= SW_IDLE;
                        ost_cnt_reg <= ost_cnt_reg + 10'h001;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // divider
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= 9'h000;
        end else if (state_reg == SW_START || !cfg_loaded_reg) begin
            div_cnt_reg <= 9'h000;
        end else if (src_tick) begin
            div_cnt_reg <= raw_tick ? 9'h000 : div_cnt_reg + 9'h001;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fosc_tick <= 1'b0;
        end else begin
            fosc_tick <= raw_tick;
        end
    end

    // ****************************************
    // analog controls
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            internal_freq_select <= `SCSS_FREQ_RESET;
            amp_gain             <= 2'h0;
            ext_power            <= 2'h0;
            pll_enable           <= 1'b0;
            ost_active           <= 1'b0;
        end else begin
            internal_freq_select <= freq_reg;
            pll_enable <= cur_src_reg == SRC_EXT_PLL;
            ost_active <= state_reg == SW_START && ost_needed;
            case (fext_reg)
                `SCSS_FEXT_LP: amp_gain <= 2'h1;
                `SCSS_FEXT_XT: amp_gain <= 2'h2;
                `SCSS_FEXT_HS: amp_gain <= 2'h3;
                default:       amp_gain <= 2'h0;
            endcase
            case (fext_reg)
                `SCSS_FEXT_ECH: ext_power <= 2'h3;
                `SCSS_FEXT_ECM: ext_power <= 2'h2;
                `SCSS_FEXT_ECL: ext_power <= 2'h1;
                default:        ext_power <= 2'h0;
            endcase
        end
    end

    // ****************************************
    // clock out pin
    // ****************************************
    // two ticks high, two low: a quarter of the system rate
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cko_cnt_reg <= 2'h0;
        end else if (raw_tick) begin
            cko_cnt_reg <= cko_cnt_reg + 2'h1;
        end
    end

    // crystal modes own the pin for the amplifier
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_out_pin_out <= 1'b0;
            clk_out_pin_oe  <= 1'b0;
            gpio_in         <= 1'b0;
        end else begin
            clk_out_pin_out <= clkout_on ? cko_cnt_reg[1] : gpio_out;
            clk_out_pin_oe  <= clkout_on || (!xtal_mode && gpio_oe);
            gpio_in         <= xtal_mode ? 1'b0 : clk_out_pin_in;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_freq_code_range: assert property (
        @(posedge sys_clk) disable iff (rst)
        internal_freq_select <= `SCSS_FREQ_MAX)
        else $error("fast oscillator code out of range");

    a_freq_write_lands: assert property (
        @(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == `SCSS_ADDR_FREQ && reg_wdata[3:0] <= `SCSS_FREQ_MAX
        |-> ##2 internal_freq_select == $past(reg_wdata[3:0], 2))
        else $error("frequency write not applied");

    a_lf_tick_source: assert property (
        @(posedge sys_clk) disable iff (rst)
        raw_tick && cur_src_reg == SRC_LF |-> lf_osc_tick)
        else $error("slow source tick without oscillator");

    a_pll_follows_src: assert property (
        @(posedge sys_clk) disable iff (rst)
        cur_src_reg == SRC_EXT_PLL |=> pll_enable)
        else $error("pll not enabled");

    a_xtal_pin_free: assert property (
        @(posedge sys_clk) disable iff (rst)
        xtal_mode |=> !clk_out_pin_oe)
        else $error("pin driven in crystal mode");

    a_clkout_quarter: assert property (
        @(posedge sys_clk) disable iff (rst)
        clkout_on && raw_tick && cko_cnt_reg[0]
        |-> ##2 clk_out_pin_out != $past(clk_out_pin_out))
        else $error("clock out not at quarter rate");

    a_reset_source: assert property (
        @(posedge sys_clk) disable iff (rst)
        !cfg_loaded_reg |=> cur_src_reg == code_to_src($past(reset_clock_source_cfg)))
        else $error("reset source not from config");

    a_switch_take: assert property (
        @(posedge sys_clk) disable iff (rst)
        state_reg == SW_WAIT_OLD && raw_tick
        |=> cur_src_reg == code_to_src($past(next_source_select_reg)) && state_reg == SW_START)
        else $error("switch did not take new source");

    a_ec_no_ost: assert property (
        @(posedge sys_clk) disable iff (rst)
        cfg_loaded_reg && state_reg == SW_START && !ost_needed |=> state_reg == SW_IDLE)
        else $error("start-up wait in external clock mode");

    a_halt_keeps: assert property (
        @(posedge sys_clk) disable iff (rst)
        state_reg == SW_IDLE && !src_tick && !pending |=> $stable(div_cnt_reg))
        else $error("state moved without source tick");

    a_gain_map: assert property (
        @(posedge sys_clk) disable iff (rst)
        fext_reg == `SCSS_FEXT_HS |=> amp_gain == 2'h3)
        else $error("high gain not selected");

    a_no_runt: assert property (
        @(posedge sys_clk) disable iff (rst)
        state_reg == SW_START |=> !fosc_tick)
        else $error("tick during source switch");

endmodule // scss_top

`default_nettype wire

// ### scss_ext_osc.sv
// external oscillator module feeding the first oscillator pin
// assumes the bench samples the pin on sys_clk
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// oscillator module
// ****************************************
module scss_ext_osc (
    // clock
    input  wire logic       sys_clk,
    // control
    input  wire logic       run,
    input  wire logic [3:0] half_cycles,
    // pin
    output logic            osc_pin
);
    logic [3:0] cnt_reg = 4'h0;

    initial osc_pin = 1'b0;

    // a stopped module holds its level, no free-running clock
    always @(posedge sys_clk) begin
        if (run) begin
            if (cnt_reg >= half_cycles - 4'h1) begin
                cnt_reg <= 4'h0;
                osc_pin <= ~osc_pin;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end
endmodule // scss_ext_osc
`default_nettype wire

// ### testbench.sv
// self-checking bench of the clock source selector
// assumes scss_top, scss_ext_osc and scss_defines.svh
`timescale 1ns/1ps
`default_nettype none
`include "scss_defines.svh"

module testbench;
    logic        sys_clk, rst, reg_wr, reg_rd, clock_output_enable;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
    logic [2:0]  reset_clock_source_cfg, external_osc_mode_cfg;
    logic        crystal_in_pin, hf_osc_tick, lf_osc_tick, pll_tick;
    logic [3:0]  internal_freq_select, osc_half, fsel;
    logic [1:0]  amp_gain, ext_power;
    logic        pll_enable, ost_active, fosc_tick, osc_run, rd_d, co_watch, co_prev;
    logic        clk_out_pin_out, clk_out_pin_oe, gpio_out, gpio_oe, gpio_in;
    wire logic   pin_lvl;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    int          num_errors, total_checks, cyc, gap, gap_min, last_gap, co_ticks, fcount, n0;

    // ****************************************
    // pin, clock, oscillator taps
    // ****************************************
    // nobody drives: the board pull-up wins
    assign pin_lvl = clk_out_pin_oe ? clk_out_pin_out : 1'b1;

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        hf_osc_tick <= (cyc % 3) == 2;
        lf_osc_tick <= (cyc % 20) == 19;
        pll_tick <= (cyc % 2) == 1;
        if (cyc == 60000) begin
            num_errors++;
            give_verdict();
        end
    end

    scss_top scss_top_i (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reset_clock_source_cfg(reset_clock_source_cfg),
        .external_osc_mode_cfg(external_osc_mode_cfg),
        .clock_output_enable(clock_output_enable), .crystal_in_pin(crystal_in_pin),
        .hf_osc_tick(hf_osc_tick), .lf_osc_tick(lf_osc_tick), .pll_tick(pll_tick),
        .internal_freq_select(internal_freq_select), .amp_gain(amp_gain),
        .ext_power(ext_power), .pll_enable(pll_enable), .ost_active(ost_active),
        .fosc_tick(fosc_tick), .clk_out_pin_in(pin_lvl),
        .clk_out_pin_out(clk_out_pin_out), .clk_out_pin_oe(clk_out_pin_oe),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in)
    );

    scss_ext_osc scss_ext_osc_i (
        .sys_clk(sys_clk), .run(osc_run), .half_cycles(osc_half), .osc_pin(crystal_in_pin)
    );

    // ****************************************
    // checking
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read notes carry {mask, data}; mask 0 means a poll, not compared
    always @(posedge sys_clk) begin
        rd_d <= reg_rd;
        if (rd_d && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[15:8] != 8'h00) chk(reg_rdata & e[15:8], e[7:0]);
        end
        if (fosc_tick) begin
            fcount <= fcount + 1;
            last_gap <= gap;
            gap <= 1;
            if (gap < gap_min) gap_min <= gap;
        end else begin
            gap <= gap + 1;
        end
        if (clk_out_pin_out !== co_prev) begin
            co_prev <= clk_out_pin_out;
            co_ticks <= int'(fosc_tick);
            if (co_watch) chk(co_ticks, 2);
        end else if (fosc_tick) begin
            co_ticks <= co_ticks + 1;
        end
    end

    // ****************************************
    // bus and sequencing tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] d);
        exp_q.push_back({m, d});
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        v = 8'hff;
        while (v[`SCSS_BUSY_BIT] !== 1'b0 && n < 4000) begin
            rd(`SCSS_ADDR_STAT, 8'h00, 8'h00);
            @(negedge sys_clk);
            v = reg_rdata;
            n++;
        end
        chk(v[`SCSS_BUSY_BIT], 1'b0);
    endtask

    task automatic do_reset(input logic [2:0] s, input logic [2:0] m, input logic c);
        @(posedge sys_clk);
        rst <= 1'b1;
        reset_clock_source_cfg <= s;
        external_osc_mode_cfg <= m;
        clock_output_enable <= c;
        repeat (16) @(posedge sys_clk);
        chk(internal_freq_select, `SCSS_FREQ_RESET);
        chk(fosc_tick, 1'b0);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    // the gap across a switch may differ from both the old and the new period
    task automatic period_is(input int p);
        repeat (2 * p + 4) @(posedge sys_clk);
        gap_min <= 100000;
        repeat (4 * p + 8) @(posedge sys_clk);
        chk(last_gap, p);
        chk(gap_min, p);
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {sys_clk, reg_wr, reg_rd, gpio_out, gpio_oe, rd_d, co_watch, co_prev} = '0;
        {reg_addr, reg_wdata, num_errors, total_checks, cyc, gap, fcount, co_ticks} = '0;
        {rst, osc_run, clock_output_enable} = 3'h7;
        {reset_clock_source_cfg, external_osc_mode_cfg} = {`SCSS_NEXT_SOURCE_SELECT_HF, 3'h0};
        {hf_osc_tick, lf_osc_tick, pll_tick} = 3'h0;
        osc_half = 4'h3;
        gap_min = 100000;
        last_gap = 0;
        n0 = $urandom(32'h0c47921f);
        for (int i = 0; i < 7; i++) begin
            do_reset(`SCSS_NEXT_SOURCE_SELECT_HF, i[2:0], 1'b1);
            chk(amp_gain, (i == 4) ? 1 : (i == 5) ? 2 : (i == 6) ? 3 : 0);
            chk(ext_power, (i < 3) ? 3 - i : 0);
            chk(clk_out_pin_oe, i < 4);
            wait_idle();
            rd(`SCSS_ADDR_STAT, 8'hff, 8'h60);
        end
        for (int i = 0; i < 9; i++) begin
            wr(`SCSS_ADDR_FREQ, i[7:0]);
            rd(`SCSS_ADDR_FREQ, 8'h0f, i[7:0]);
        end
        fsel = `SCSS_FREQ_MAX;
        repeat (20) begin
            v = 8'($urandom_range(0, 15));
            wr(`SCSS_ADDR_FREQ, v);
            if (v <= 8'h08) fsel = v[3:0];
            rd(`SCSS_ADDR_FREQ, 8'h0f, {4'h0, fsel});
            chk(internal_freq_select, fsel);
        end
        rd(8'h05, 8'hff, 8'h00);
        // crystal mode on the external source waits for the start-up count
        do_reset(`SCSS_NEXT_SOURCE_SELECT_EXT, `SCSS_FEXT_HS, 1'b1);
        chk(ost_active, 1'b1);
        chk(clk_out_pin_oe, 1'b0);
        wait_idle();
        chk(ost_active, 1'b0);
        period_is(6);
        do_reset(`SCSS_NEXT_SOURCE_SELECT_EXT, `SCSS_FEXT_ECH, 1'b1);
        chk(ost_active, 1'b0);
        period_is(6);
        co_watch <= 1'b1;
        period_is(6);
        co_watch <= 1'b0;
        chk(clk_out_pin_oe, 1'b1);
        osc_run <= 1'b0;
        // a last edge may still be in flight when the module stops
        repeat (4) @(posedge sys_clk);
        n0 = fcount;
        repeat (100) @(posedge sys_clk);
        chk(fcount - n0, 0);
        wr(`SCSS_ADDR_CTRL, 8'h60);
        repeat (50) @(posedge sys_clk);
        rd(`SCSS_ADDR_STAT, 8'hff, 8'hf0);
        osc_run <= 1'b1;
        wait_idle();
        rd(`SCSS_ADDR_STAT, 8'hff, 8'h60);
        wr(`SCSS_ADDR_CTRL, 8'h62);
        wait_idle();
        period_is(12);
        wr(`SCSS_ADDR_CTRL, 8'h51);
        wr(`SCSS_ADDR_FREQ, 8'h00);
        wait_idle();
        period_is(40);
        wr(`SCSS_ADDR_CTRL, 8'h21);
        wait_idle();
        chk(pll_enable, 1'b1);
        period_is(4);
        wr(`SCSS_ADDR_CTRL, 8'h30);
        wr(`SCSS_ADDR_CTRL, 8'h6a);
        rd(`SCSS_ADDR_STAT, 8'hff, 8'h21);
        wr(`SCSS_ADDR_CTRL, 8'h29);
        wait_idle();
        rd(`SCSS_ADDR_CTRL, 8'h7f, 8'h29);
        period_is(1024);
        // clock out off: the second pin is plain user I/O
        do_reset(`SCSS_NEXT_SOURCE_SELECT_HF, `SCSS_FEXT_ECH, 1'b0);
        v[0] = 1'($urandom);
        gpio_oe <= 1'b1;
        gpio_out <= v[0];
        repeat (3) @(posedge sys_clk);
        chk(clk_out_pin_oe, 1'b1);
        chk(clk_out_pin_out, v[0]);
        chk(gpio_in, v[0]);
        gpio_oe <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(clk_out_pin_oe, 1'b0);
        chk(gpio_in, 1'b1);
        repeat (4) @(posedge sys_clk);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
